// ==== hw/eepc_ctrl.sv ====
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
//Contract
//- two bits select program/byte/block/bulk operation
//- byte erase clears only addressed byte
//- block erase clears aligned 64-byte block
//- bulk erase clears all 256 bytes
//- latch set: array writes capture address/data
//- reads blocked after latched write
//- latch clear: array reads normal
//- osc select picks RC or CPU clock
//- power bit drives pump and array power
//- power bit writable only while latch set
//- pump enable bit readable, writable, reset clear
//- erased reads ones; program only clears bits
//- array is 256 bytes, one control register
module eepc_ctrl
   import eepc_pkg::*;
(
   input  wire logic        clk,        // 100 MHz system clock
   input  wire logic        rst,        // async reset, active high
   input  wire logic        hsel,       // slave select
   input  wire logic [31:0] haddr,      // byte address
   input  wire logic [1:0]  htrans,     // transfer type
   input  wire logic        hwrite,     // write when high
   input  wire logic [2:0]  hsize,      // word only
   input  wire logic [31:0] hwdata,     // write data
   input  wire logic        hready,     // bus ready in
   output logic      [31:0] hrdata,     // read data
   output logic             hreadyout,  // always ready
   output logic      [1:0]  hresp,      // always okay
   output logic             pump_on,    // charge pump running
   output logic             hv_applied, // hv on array
   output logic             array_osc_select, // rc clock chosen
   output logic             latch_held  // a write is held
);

   logic [7:0]  ctrl_q, ctrl_d;
   logic [7:0]  mem_q [ARRAY_BYTES];
   logic [7:0]  mem_d [ARRAY_BYTES];
   logic [7:0]  hold_addr_q, hold_addr_d;
   logic [7:0]  hold_data_q, hold_data_d;
   logic        held_q, held_d;
   logic        hv_prev_q, hv_prev_d;
   eepc_state_e st_q, st_d;
   logic [11:0] aaddr_q, aaddr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [3:0]  outs_q, outs_d;
   logic        rdy_q, rdy_d;
   logic [1:0]  resp_q, resp_d;

   function automatic logic in_array(input logic [11:0] a);
      in_array = (a & ARRAY_MASK) == ARRAY_BASE;
   endfunction : in_array

   function automatic logic [1:0] blk_of(input logic [7:0] a);
      blk_of = a[7:6];
   endfunction : blk_of

   wire logic        latch_w = ctrl_q[LATCH_BIT];
   wire logic        hv_w    = ctrl_q[HV_BIT];
   wire logic [1:0]  op_w    = {ctrl_q[OPHI_BIT], ctrl_q[OPLO_BIT]};
   wire logic        take    = hsel && hready && htrans == HTRANS_NSEQ;
   // held operation commits as the power bit falls
   wire logic        commit  = hv_prev_q && !hv_w && held_q;

   // block geometry for the erase checks
   localparam logic [7:0] NEXT_BYTE = 8'h01;
   localparam logic [7:0] BLK_STEP  = 8'h40;
   localparam logic [5:0] BLK_FIRST = 6'h00;
   localparam logic [5:0] BLK_LAST  = 6'h3f;

   // bus phase tracking
   always_comb begin
      st_d    = st_q;
      aaddr_d = aaddr_q;
      if (hready) begin
         st_d = EEPC_IDLE;
         if (take) begin
            st_d    = hwrite ? EEPC_WRITE : EEPC_READ;
            aaddr_d = haddr[11:0];
         end
      end
   end

   // control register, holding latch, array
   always_comb begin
      logic [7:0] wv;
      logic       lat_next;
      wv          = hwdata[7:0];
      ctrl_d      = ctrl_q;
      hold_addr_d = hold_addr_q;
      hold_data_d = hold_data_q;
      held_d      = held_q;
      hv_prev_d   = hv_w;
      lat_next    = latch_w;
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (st_q == EEPC_WRITE && aaddr_q == CTRL_ADDR) begin
         ctrl_d[PUMP_BIT]  = wv[PUMP_BIT];
         ctrl_d[OPHI_BIT]  = wv[OPHI_BIT];
         ctrl_d[OPLO_BIT]  = wv[OPLO_BIT];
         ctrl_d[LATCH_BIT] = wv[LATCH_BIT];
         ctrl_d[OSC_BIT]   = wv[OSC_BIT];
         lat_next          = wv[LATCH_BIT];
         if (latch_w) begin
            ctrl_d[HV_BIT] = wv[HV_BIT];
         end
      end
      if (st_q == EEPC_WRITE && in_array(aaddr_q) && latch_w) begin
         hold_addr_d = aaddr_q[7:0];
         hold_data_d = wv;
         held_d      = 1'b1;
      end
      // hv pulse falls: commit held operation
      if (hv_prev_q && !hv_w && held_q) begin
         for (int i = 0; i < ARRAY_BYTES; i++) begin
            case (op_w)
               OP_PROGRAM: if (8'(i) == hold_addr_q)
                  mem_d[i] = mem_q[i] & hold_data_q;
               OP_BYTE_ERA: if (8'(i) == hold_addr_q)
                  mem_d[i] = ERASED_BYTE;
               OP_BLOCK_ERA: if (blk_of(8'(i)) == blk_of(hold_addr_q))
                  mem_d[i] = ERASED_BYTE;
               default: mem_d[i] = ERASED_BYTE;
            endcase
         end
      end
      if (!lat_next) begin
         held_d = 1'b0;
      end
   end

   // read data and outputs
   always_comb begin
      hrdata_d = ZERO_WORD;
      if (take && !hwrite) begin
         // next state: a write in its data phase is seen
         if (haddr[11:0] == CTRL_ADDR) begin
            hrdata_d = {24'h000000, ctrl_d};
         end else if (in_array(haddr[11:0])) begin
            if (!(ctrl_d[LATCH_BIT] && held_d))
               hrdata_d = {24'h000000, mem_d[haddr[7:0]]};
         end
      end else if (st_q != EEPC_READ) begin
         hrdata_d = hrdata_q;
      end
      outs_d = {ctrl_d[PUMP_BIT] | ctrl_d[HV_BIT], ctrl_d[HV_BIT],
                ctrl_d[OSC_BIT], held_d};
      // bus status kept in flops so every output is registered
      rdy_d  = 1'b1;
      resp_d = HRESP_OKAY;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q        <= EEPC_IDLE;
         aaddr_q     <= 12'h000;
         ctrl_q      <= CTRL_RESET;
         hold_addr_q <= 8'h00;
         hold_data_q <= 8'h00;
         held_q      <= 1'b0;
         hv_prev_q   <= 1'b0;
         hrdata_q    <= ZERO_WORD;
         outs_q      <= 4'h0;
         rdy_q       <= 1'b1;
         resp_q      <= HRESP_OKAY;
         for (int i = 0; i < ARRAY_BYTES; i++) begin
            mem_q[i] <= ERASED_BYTE;
         end
      end else begin
         st_q        <= st_d;
         aaddr_q     <= aaddr_d;
         ctrl_q      <= ctrl_d;
         hold_addr_q <= hold_addr_d;
         hold_data_q <= hold_data_d;
         held_q      <= held_d;
         hv_prev_q   <= hv_prev_d;
         hrdata_q    <= hrdata_d;
         outs_q      <= outs_d;
         rdy_q       <= rdy_d;
         resp_q      <= resp_d;
         mem_q       <= mem_d;
      end
   end

   assign hrdata           = hrdata_q;
   assign hreadyout        = rdy_q;
   assign hresp            = resp_q;
   assign pump_on          = outs_q[3];
   assign hv_applied       = outs_q[2];
   assign array_osc_select = outs_q[1];
   assign latch_held       = outs_q[0];

   a_hv_needs_latch: assert property (@(posedge clk) disable iff (rst)
      $rose(ctrl_q[HV_BIT]) |-> $past(ctrl_q[LATCH_BIT]))
      else $error("power bit set without latch");
   a_read_blocked: assert property (@(posedge clk) disable iff (rst)
      (take && !hwrite && in_array(haddr[11:0])
       && ctrl_d[LATCH_BIT] && held_d)
      |=> hrdata == ZERO_WORD)
      else $error("array read not blocked");
   a_hold_discard: assert property (@(posedge clk) disable iff (rst)
      !ctrl_q[LATCH_BIT] |-> !held_q)
      else $error("held pair kept without latch");
   a_hv_output: assert property (@(posedge clk) disable iff (rst)
      hv_applied == ctrl_q[HV_BIT])
      else $error("power output mismatch");
   a_bulk_erase: assert property (@(posedge clk) disable iff (rst)
      (hv_prev_q && !hv_w && held_q && op_w == OP_BULK_ERA)
      |=> mem_q[0] == ERASED_BYTE && mem_q[ARRAY_BYTES-1] == ERASED_BYTE)
      else $error("bulk erase missed bytes");
   a_prog_clears: assert property (@(posedge clk) disable iff (rst)
      (hv_prev_q && !hv_w && held_q && op_w == OP_PROGRAM)
      |=> (mem_q[$past(hold_addr_q)] & ~$past(mem_q[hold_addr_q])) == 8'h00)
      else $error("program set a bit");
   a_capture: assert property (@(posedge clk) disable iff (rst)
      (st_q == EEPC_WRITE && in_array(aaddr_q) && latch_w)
      |=> held_q && hold_addr_q == $past(aaddr_q[7:0]))
      else $error("latched write not captured");
   a_op_write: assert property (@(posedge clk) disable iff (rst)
      (st_q == EEPC_WRITE && aaddr_q == CTRL_ADDR)
      |=> op_w == $past({hwdata[OPHI_BIT], hwdata[OPLO_BIT]}))
      else $error("op field not written");

   a_ctrl_readback: assert property (@(posedge clk) disable iff (rst)
      (take && !hwrite && haddr[11:0] == CTRL_ADDR)
      |=> hrdata == {24'h000000, ctrl_q})
      else $error("control read mismatch");

   a_byte_erase: assert property (@(posedge clk) disable iff (rst)
      (commit && op_w == OP_BYTE_ERA)
      |=> mem_q[$past(hold_addr_q)] == ERASED_BYTE
          && mem_q[$past(hold_addr_q) ^ NEXT_BYTE]
             == $past(mem_q[hold_addr_q ^ NEXT_BYTE]))
      else $error("byte erase wrong extent");

   a_block_erase: assert property (@(posedge clk) disable iff (rst)
      (commit && op_w == OP_BLOCK_ERA)
      |=> mem_q[{blk_of($past(hold_addr_q)), BLK_FIRST}] == ERASED_BYTE
          && mem_q[{blk_of($past(hold_addr_q)), BLK_LAST}] == ERASED_BYTE
          && mem_q[$past(hold_addr_q) ^ BLK_STEP]
             == $past(mem_q[hold_addr_q ^ BLK_STEP]))
      else $error("block erase wrong extent");

   a_normal_read: assert property (@(posedge clk) disable iff (rst)
      (take && !hwrite && in_array(haddr[11:0]) && !ctrl_d[LATCH_BIT])
      |=> hrdata == {24'h000000, mem_q[$past(haddr[7:0])]})
      else $error("array read wrong");

   a_osc_output: assert property (@(posedge clk) disable iff (rst)
      array_osc_select == ctrl_q[OSC_BIT])
      else $error("oscillator output mismatch");

   // pump runs with pump or power
   a_pump_output: assert property (@(posedge clk) disable iff (rst)
      pump_on == (ctrl_q[PUMP_BIT] | ctrl_q[HV_BIT]))
      else $error("pump output mismatch");

   a_hv_refused: assert property (@(posedge clk) disable iff (rst)
      (st_q == EEPC_WRITE && aaddr_q == CTRL_ADDR && !latch_w)
      |=> ctrl_q[HV_BIT] == $past(ctrl_q[HV_BIT]))
      else $error("power bit written without latch");

   a_pump_write: assert property (@(posedge clk) disable iff (rst)
      (st_q == EEPC_WRITE && aaddr_q == CTRL_ADDR)
      |=> ctrl_q[PUMP_BIT] == $past(hwdata[PUMP_BIT]))
      else $error("pump bit not written");

   a_held_output: assert property (@(posedge clk) disable iff (rst)
      latch_held == held_q)
      else $error("held output mismatch");

   a_mem_quiet: assert property (@(posedge clk) disable iff (rst)
      !commit
      |=> mem_q[$past(hold_addr_q)] == $past(mem_q[hold_addr_q]))
      else $error("array changed without commit");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
      (take && !hwrite && haddr[11:0] != CTRL_ADDR
       && !in_array(haddr[11:0]))
      |=> hrdata == ZERO_WORD)
      else $error("unmapped read not zero");

   a_bus_okay: assert property (@(posedge clk) disable iff (rst)
      hreadyout && hresp == HRESP_OKAY)
      else $error("bus status wrong");

endmodule : eepc_ctrl

// ==== pkg/eepc_pkg.sv ====
package eepc_pkg;
   // register map (byte addresses on the AHB-Lite slave)
   localparam logic [11:0] CTRL_ADDR    = 12'h01c;
   localparam logic [11:0] ARRAY_BASE   = 12'h200;
   localparam logic [11:0] ARRAY_MASK   = 12'hf00;
   localparam int          ARRAY_BYTES  = 256;
   // control register fields
   localparam int          PUMP_BIT     = 6;
   localparam int          OPHI_BIT     = 4;
   localparam int          OPLO_BIT     = 3;
   localparam int          LATCH_BIT    = 2;
   localparam int          OSC_BIT      = 1;
   localparam int          HV_BIT       = 0;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [7:0]  ERASED_BYTE  = 8'hff;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
   localparam logic [1:0]  OP_PROGRAM   = 2'h0;
   localparam logic [1:0]  OP_BYTE_ERA  = 2'h1;
   localparam logic [1:0]  OP_BLOCK_ERA = 2'h2;
   localparam logic [1:0]  OP_BULK_ERA  = 2'h3;
   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
   localparam logic [1:0]  HRESP_OKAY   = 2'h0;
   typedef enum logic [1:0] {
      EEPC_OP_PROGRAM   = 2'h0,
      EEPC_OP_BYTE_ERA  = 2'h1,
      EEPC_OP_BLOCK_ERA = 2'h2,
      EEPC_OP_BULK_ERA  = 2'h3
   } eepc_op_e;
   // bus data phase states, one-hot
   typedef enum logic [2:0] {
      EEPC_IDLE  = 3'h1,
      EEPC_WRITE = 3'h2,
      EEPC_READ  = 3'h4
   } eepc_state_e;
endpackage : eepc_pkg

// ==== sim/eepc_cpu.sv ====
`timescale 1ns/100ps
module eepc_cpu
   import eepc_pkg::*;
#(
   parameter int SETTLE = 8,
   parameter int PULSE  = 20,
   parameter int DECAY  = 4
)(
   input  wire logic        clk,    // system clock
   input  wire logic        hready, // bus ready
   input  wire logic [31:0] hrdata, // read data
   output logic             hsel,   // slave select
   output logic      [31:0] haddr,  // byte address
   output logic      [1:0]  htrans, // transfer type
   output logic             hwrite, // write when high
   output logic      [2:0]  hsize,  // word size
   output logic      [31:0] hwdata, // write data
   output logic             hang    // bus never answered
);
   initial begin
      hsel   = 1'b1;
      haddr  = ZERO_WORD;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = ZERO_WORD;
      hang   = 1'b0;
   end
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 16);
      if (hready !== 1'b1) hang <= 1'b1;
   endtask : wait_rdy
   // caller starts right after a rising edge
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] q);
      haddr  <= {20'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
      q = hrdata;
   endtask : xfer
   task automatic op(input logic [1:0] m, input logic [11:0] a,
                     input logic [7:0] d);
      logic [31:0] q;
      logic [7:0]  c;
      c = 8'h46 | {3'h0, m, 3'h0};
      xfer(1'b1, CTRL_ADDR, 8'h02, q);
      repeat (SETTLE) @(posedge clk);
      xfer(1'b1, CTRL_ADDR, c, q);
      xfer(1'b1, a, d, q);
      xfer(1'b1, CTRL_ADDR, c | 8'h01, q);
      repeat (PULSE) @(posedge clk);
      xfer(1'b1, CTRL_ADDR, c, q);
      repeat (DECAY) @(posedge clk);
      xfer(1'b1, CTRL_ADDR, 8'h00, q);
   endtask : op
endmodule : eepc_cpu

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
   import eepc_pkg::*;
;
   logic        clk, rst, hsel, hwrite, hready, pump_on, hv_applied;
   logic        array_osc_select, latch_held, hang;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans, hresp;
   logic [2:0]  hsize;
   int          err_count, n_compared;
   eepc_ctrl dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .pump_on(pump_on), .hv_applied(hv_applied),
      .array_osc_select(array_osc_select), .latch_held(latch_held));
   eepc_cpu cpu (.clk(clk), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hang(hang));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      cpu.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rx(input logic [11:0] a, input logic [31:0] e);
      cpu.xfer(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rx
   task automatic t_ctrl();
      rx(CTRL_ADDR, 32'h0);
      chk({29'h0, hv_applied, pump_on, array_osc_select}, 32'h0);
      wr(CTRL_ADDR, 8'h01);
      rx(CTRL_ADDR, 32'h0);
      wr(CTRL_ADDR, 8'h05);
      rx(CTRL_ADDR, 32'h04);
      wr(CTRL_ADDR, 8'h5e);
      rx(CTRL_ADDR, 32'h5e);
      chk({29'h0, hv_applied, pump_on, array_osc_select}, 32'h3);
      wr(CTRL_ADDR, 8'h5f);
      rx(CTRL_ADDR, 32'h5f);
      chk({30'h0, hv_applied, pump_on}, 32'h3);
      wr(CTRL_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'ha0);
      rx(CTRL_ADDR, 32'h0);
      rx(12'h100, 32'h0);
      chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
      chk({31'h0, hready}, 32'h1);
   endtask : t_ctrl
   task automatic t_prog();
      wr(12'h203, 8'h00);
      rx(12'h203, 32'hff);
      chk({31'h0, latch_held}, 32'h0);
      rx(12'h200, 32'hff);
      wr(CTRL_ADDR, 8'h44);
      wr(12'h201, 8'h11);
      wr(12'h202, 8'h5a);
      rx(12'h202, 32'h0);
      chk({31'h0, latch_held}, 32'h1);
      wr(CTRL_ADDR, 8'h45);
      wr(CTRL_ADDR, 8'h44);
      wr(CTRL_ADDR, 8'h00);
      rx(12'h201, 32'hff);
      rx(12'h202, 32'h5a);
      cpu.op(OP_PROGRAM, 12'h202, 8'h0f);
      rx(12'h202, 32'h0a);
   endtask : t_prog
   task automatic t_erase();
      cpu.op(OP_PROGRAM, 12'h240, 8'h00);
      cpu.op(OP_PROGRAM, 12'h280, 8'h00);
      cpu.op(OP_BYTE_ERA, 12'h202, 8'h00);
      rx(12'h202, 32'hff);
      rx(12'h240, 32'h0);
      cpu.op(OP_BLOCK_ERA, 12'h27f, 8'h00);
      rx(12'h240, 32'hff);
      rx(12'h280, 32'h0);
      cpu.op(OP_PROGRAM, 12'h202, 8'h00);
      cpu.op(OP_BULK_ERA, 12'h2c0, 8'h00);
      rx(12'h280, 32'hff);
      rx(12'h202, 32'hff);
      wr(CTRL_ADDR, 8'h44);
      wr(12'h210, 8'h00);
      wr(CTRL_ADDR, 8'h00);
      rx(12'h210, 32'hff);
      chk({31'h0, latch_held}, 32'h0);
   endtask : t_erase
   task automatic t_reset();
      wr(CTRL_ADDR, 8'h46);
      wr(12'h230, 8'h00);
      wr(CTRL_ADDR, 8'h47);
      @(posedge clk);
      chk({29'h0, hv_applied, pump_on, array_osc_select}, 32'h7);
      chk({31'h0, latch_held}, 32'h1);
      rst <= 1'b1;
      @(posedge clk);
      chk({29'h0, hv_applied, pump_on, array_osc_select}, 32'h0);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rx(CTRL_ADDR, 32'h0);
      rx(12'h230, 32'hff);
      chk({31'h0, latch_held}, 32'h0);
   endtask : t_reset
   task automatic results();
      $display("compares %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // a bus that never answers ends the run
   always @(posedge hang) begin
      err_count++;
      results();
   end
   initial begin
      err_count  = 0;
      n_compared = 0;
      rst        = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_ctrl();
      t_prog();
      t_erase();
      t_reset();
      results();
   end
endmodule : tb_top
